// ### urt_pkg.sv
// shared constants for the receive timeout and fifo trigger block
package urt_pkg;
    // ****************************************
    // control bit position and control byte reset value
    // ****************************************
    localparam int PERIODIC_BIT = 6;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int DATA_W = 8;
    localparam int LVL_W = 6;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W = 16;
    localparam logic [7:0] TMO_HI_RESET = 8'h00;
    localparam logic [7:0] TMO_LO_RESET = 8'h40;
    localparam logic [LVL_W-1:0] LVL_RESET = 6'h01;
    localparam logic [5:0] FIFO_CAP = 6'h20;
    typedef enum logic [1:0] {URT_IDLE, URT_COUNT, URT_FIRED} urt_tmo_state_t;
endpackage

// ### urt_skid.sv
// two-entry buffer for the receive data path
`timescale 1ns/1ps
module urt_skid (
    input wire logic clock,                            // 25 MHz clock
    input wire logic rst_b,                            // async reset, active low
    input wire logic clk_en,                           // freezes state when low
    input wire logic in_valid,                         // word offered
    output logic in_ready,                             // room available
    input wire logic [urt_pkg::DATA_W-1:0] in_data,    // word in
    output logic out_valid,                            // word available
    input wire logic out_ready,                        // drain accepts
    output logic [urt_pkg::DATA_W-1:0] out_data        // word out
);
    logic [urt_pkg::DATA_W-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    wire push = in_valid && in_ready && clk_en;
    wire pop = out_valid && out_ready && clk_en;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            mem[0] <= '0;
            mem[1] <= '0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ### urt_rx_timeout.sv
// receive timeout interrupt and dma trigger logic of a serial port
`timescale 1ns/1ps
module urt_rx_timeout (
    input wire logic clock,                               // 25 MHz clock
    input wire logic rst_b,                               // async reset, active low
    input wire logic clk_en,                              // freezes state when low
    input wire logic [7:0] ext_feature_ctrl_two,          // control byte, bit 6 mode
    input wire logic [7:0] rx_timeout_count_hi,           // timeout count high byte
    input wire logic [7:0] rx_timeout_count_lo,           // timeout count low byte
    input wire logic [urt_pkg::LVL_W-1:0] rx_trig_level,  // rx trigger level
    input wire logic [urt_pkg::LVL_W-1:0] tx_trig_level,  // tx trigger level
    input wire logic [5:0] tx_fifo_level,                 // tx fifo fill level
    input wire logic irq_ident_rd,                        // ident register read pulse
    input wire logic rx_holding_rd,                       // data register read pulse
    input wire logic modem_state_rd,                      // modem status read pulse
    input wire logic line_state_rd,                       // line status read pulse
    input wire logic rx_char_valid,                       // character from line
    input wire logic [urt_pkg::DATA_W-1:0] rx_char,       // character value
    output logic rx_char_ready,                           // fifo can take character
    output logic rx_out_valid,                            // data available and reader ready
    input wire logic rx_out_ready,                        // reader ready, gates rx_out_valid only; rx_holding_rd takes data
    output logic [urt_pkg::DATA_W-1:0] rx_out_data,       // data to reader
    output logic [5:0] rx_fifo_level,                     // receive fifo fill level
    output logic rx_timeout_irq,                          // timeout interrupt level
    output logic rx_dma_req,                              // rx dma trigger level
    output logic tx_dma_req,                              // tx dma trigger level
    output logic level_warn                               // a trigger level is not power of 2
);
    // ****************************************
    // receive storage
    // ****************************************
    logic [urt_pkg::DATA_W-1:0] fifo_mem [urt_pkg::FIFO_DEPTH];
    logic [4:0] wr_idx;
    logic [4:0] rd_idx;
    logic [5:0] count;
    logic skid_valid;
    logic skid_ready;
    logic [urt_pkg::DATA_W-1:0] skid_data;
    logic [urt_pkg::DATA_W-1:0] head_data;
    logic head_valid;

    // stall on the line side reaches the source through rx_char_ready
    urt_skid u_skid (
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .in_valid(rx_char_valid),
        .in_ready(rx_char_ready),
        .in_data(rx_char),
        .out_valid(skid_valid),
        .out_ready(skid_ready),
        .out_data(skid_data)
    );

    wire fifo_full = (count == urt_pkg::FIFO_CAP);
    assign skid_ready = !fifo_full;
    wire push = skid_valid && skid_ready && clk_en;
    wire pop = rx_holding_rd && (count != 6'h00) && clk_en;
    assign head_valid = (count != 6'h00);
    assign head_data = fifo_mem[rd_idx];
    assign rx_fifo_level = count;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_idx <= 5'h00;
            rd_idx <= 5'h00;
            count <= 6'h00;
        end else begin
            if (push) begin
                wr_idx <= wr_idx + 5'h01;
            end
            if (pop) begin
                rd_idx <= rd_idx + 5'h01;
            end
            count <= count + {5'h00, push} - {5'h00, pop};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < urt_pkg::FIFO_DEPTH; gi++) begin : g_mem
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    fifo_mem[gi] <= '0;
                end else if (push && (wr_idx == 5'(gi))) begin
                    fifo_mem[gi] <= skid_data;
                end
            end
        end
    endgenerate

    // data output registered for the reader
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_out_data <= '0;
        end else if (clk_en) begin
            rx_out_data <= head_data;
        end
    end
    assign rx_out_valid = head_valid && rx_out_ready;

    // ****************************************
    // timeout counter
    // ****************************************
    // periodic mode select
    wire periodic = ext_feature_ctrl_two[urt_pkg::PERIODIC_BIT];
    // period from high and low counts
    wire [urt_pkg::CNT_W-1:0] limit = {rx_timeout_count_hi, rx_timeout_count_lo};
    logic [urt_pkg::CNT_W-1:0] idle_cnt;
    urt_pkg::urt_tmo_state_t state;
    urt_pkg::urt_tmo_state_t next_state;
    logic pend;
    wire expire = (idle_cnt >= limit) && (limit != '0);
    // original mode needs waiting data, periodic mode runs free
    wire armed = periodic || head_valid;
    // status reads restart idle time, the known disturbance
    wire restart = push || pop || modem_state_rd || line_state_rd;
    wire fire = (state == urt_pkg::URT_COUNT) && expire && armed;

    always_comb begin
        next_state = state;
        case (state)
            urt_pkg::URT_IDLE: begin
                if (armed) begin
                    next_state = urt_pkg::URT_COUNT;
                end
            end
            urt_pkg::URT_COUNT: begin
                if (!armed) begin
                    next_state = urt_pkg::URT_IDLE;
                end else if (expire) begin
                    next_state = urt_pkg::URT_FIRED;
                end
            end
            urt_pkg::URT_FIRED: begin
                // periodic mode rearms for next period
                // waiting data rearms after a clear
                if (restart || periodic || (!pend && head_valid)) begin
                    next_state = armed ? urt_pkg::URT_COUNT : urt_pkg::URT_IDLE;
                end
            end
            default: begin
                next_state = urt_pkg::URT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= urt_pkg::URT_IDLE;
            idle_cnt <= '0;
        end else if (clk_en) begin
            state <= next_state;
            if (restart || fire || (state != urt_pkg::URT_COUNT)) begin
                idle_cnt <= '0;
            end else begin
                idle_cnt <= idle_cnt + 16'h0001;
            end
        end
    end

    // ident read clears, a same cycle expiry wins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pend <= 1'b0;
        end else if (clk_en) begin
            if (fire) begin
                pend <= 1'b1;
            end else if (irq_ident_rd) begin
                pend <= 1'b0;
            end
        end
    end
    assign rx_timeout_irq = pend;

    // ****************************************
    // dma triggers
    // ****************************************
    function automatic logic pow2(input logic [urt_pkg::LVL_W-1:0] v);
        pow2 = (v != '0) && ((v & (v - 6'h01)) == '0);
    endfunction
    // flag levels that may give spurious requests
    assign level_warn = !pow2(rx_trig_level) || !pow2(tx_trig_level);
    assign rx_dma_req = (count >= rx_trig_level) && (count != 6'h00);
    assign tx_dma_req = ((urt_pkg::FIFO_CAP - tx_fifo_level) >= tx_trig_level);

    // ****************************************
    // checks
    // ****************************************
    sequence s_fire;
        fire && clk_en;
    endsequence
    a_fire_sets_irq: assert property (@(posedge clock) disable iff (!rst_b)
        s_fire |=> rx_timeout_irq) else $error("timeout expiry did not raise irq");
    a_ident_clears: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && irq_ident_rd && !fire) |=> !rx_timeout_irq)
        else $error("ident read did not clear timeout");
    a_irq_cause: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rx_timeout_irq) |-> $past(fire)) else $error("irq rose without expiry");
    // empty fifo in original mode never raises the flag
    a_orig_needs_data: assert property (@(posedge clock) disable iff (!rst_b)
        (!periodic && rx_fifo_level == 6'h00) |=> !$rose(rx_timeout_irq))
        else $error("original mode fired empty");
    a_periodic_rearm: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && state == urt_pkg::URT_FIRED && periodic) |=>
        state == urt_pkg::URT_COUNT) else $error("periodic mode did not rearm");
    // a nonzero limit lowered below the running count fires at once
    a_limit_wait: assert property (@(posedge clock) disable iff (!rst_b)
        s_fire |-> (idle_cnt == limit) || (limit != $past(limit)))
        else $error("fired before programmed count");
    a_data_rearm: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && state == urt_pkg::URT_FIRED && !pend && head_valid) |=>
        state == urt_pkg::URT_COUNT) else $error("waiting data did not rearm");
    a_status_restart: assert property (@(posedge clock) disable iff (!rst_b)
        (clk_en && (line_state_rd || modem_state_rd)) |=> idle_cnt == '0)
        else $error("status read did not restart");
    a_level_warn: assert property (@(posedge clock) disable iff (!rst_b)
        (rx_trig_level == 6'h03 || tx_trig_level == 6'h06) |-> level_warn)
        else $error("odd level not flagged");
endmodule

// ### urt_peer.sv
// serial peer model that offers received characters to the block
`timescale 1ns/1ps
module urt_peer (
    input wire logic clock,          // bench clock
    input wire logic rx_char_ready,  // receiver can take a character
    output logic rx_char_valid,      // character offered
    output logic [7:0] rx_char       // character value
);
    initial begin
        rx_char_valid = 1'b0;
        rx_char = 8'h5a;
    end
    // held until taken at a rising edge or for 200 edges; ok low if never taken
    task automatic send(input logic [7:0] b, output bit ok);
        int n;
        n = 0;
        @(negedge clock);
        rx_char_valid = 1'b1;
        rx_char = b;
        do begin
            @(posedge clock);
            ok = (rx_char_ready === 1'b1);
            n++;
        end while (!ok && n < 200);
        @(negedge clock);
        rx_char_valid = 1'b0;
        // released line must not keep showing the old character
        rx_char = ~b;
    endtask
endmodule

// ### urt_rx_timeout_test.sv
// self-checking bench for the receive timeout and dma trigger block
`timescale 1ns/1ps
module urt_rx_timeout_test;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] efr = 8'h00;
    logic [7:0] thi = 8'h00;
    logic [7:0] tlo = 8'h08;
    logic [5:0] rx_trig = 6'h01;
    logic [5:0] tx_trig = 6'h01;
    logic [5:0] tx_fill = 6'h00;
    logic [3:0] rdp = 4'h0;
    logic en = 1'b1;
    logic v, rdy, ov, irq, rxd, txd, warn;
    logic [7:0] ch, od;
    logic [5:0] lvl;
    logic [7:0] q[$];
    int n_fail = 0;
    int n_tests = 0;
    always #20 clock = ~clock;
    urt_rx_timeout DUT (.clock(clock), .rst_b(rst_b), .clk_en(en),
        .ext_feature_ctrl_two(efr), .rx_timeout_count_hi(thi), .rx_timeout_count_lo(tlo),
        .rx_trig_level(rx_trig), .tx_trig_level(tx_trig), .tx_fifo_level(tx_fill),
        .irq_ident_rd(rdp[0]), .rx_holding_rd(rdp[1]), .modem_state_rd(rdp[2]),
        .line_state_rd(rdp[3]), .rx_char_valid(v), .rx_char(ch), .rx_char_ready(rdy),
        .rx_out_valid(ov), .rx_out_ready(1'b1), .rx_out_data(od), .rx_fifo_level(lvl),
        .rx_timeout_irq(irq), .rx_dma_req(rxd), .tx_dma_req(txd), .level_warn(warn));
    urt_peer peer (.clock(clock), .rx_char_ready(rdy), .rx_char_valid(v), .rx_char(ch));
    // ****************************************
    // helpers
    // ****************************************
    task automatic end_sim;
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic bit p2(input int x);
        return x != 0 && (x & (x - 1)) == 0;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic pulse(input int k);
        @(negedge clock) rdp[k] = 1'b1;
        @(negedge clock) rdp[k] = 1'b0;
    endtask
    task automatic wirq(input int lim);
        int c;
        c = 0;
        while (irq !== 1'b1 && c < lim) begin
            @(negedge clock);
            c++;
        end
        if (irq !== 1'b1) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic push(input int n);
        logic [7:0] b;
        bit ok;
        repeat (n) begin
            b = 8'($urandom);
            peer.send(b, ok);
            if (!ok) begin
                n_fail++;
                end_sim();
            end
            q.push_back(b);
        end
    endtask
    task automatic pop;
        chk(od, q.pop_front());
        pulse(1);
        tick(2);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        end_sim();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(46496));
        repeat (6) @(posedge clock);
        @(negedge clock) rst_b = 1'b1;
        chk(irq, 0);
        chk(lvl, 0);
        chk(rxd, 0);
        for (int i = 0; i <= 32; i++) begin
            @(negedge clock);
            rx_trig = 6'(i);
            tx_trig = 6'(1 << $urandom_range(5, 0));
            tx_fill = 6'($urandom_range(32, 0));
            #1;
            chk(warn, !(p2(i) && p2(tx_trig)));
            chk(txd, (32 - tx_fill) >= tx_trig);
        end
        // corner: a non power of two tx level alone
        tx_trig = 6'h06;
        #1;
        chk(warn, 1);
        tx_trig = 6'h08;
        rx_trig = 6'h04;
        push(5);
        tick(2);
        chk(lvl, 5);
        chk(rxd, 1);
        // freeze: no counting while the enable is low
        en = 1'b0;
        tick(20);
        chk(irq, 0);
        chk(lvl, 5);
        en = 1'b1;
        wirq(40);
        tick(5);
        chk(irq, 1);
        pulse(0);
        chk(irq, 0);
        wirq(40);
        efr[urt_pkg::PERIODIC_BIT] = 1'b1;
        repeat (3) begin
            pulse(0);
            chk(irq, 0);
            wirq(30);
        end
        thi = 8'h01;
        pulse(0);
        tick(100);
        chk(irq, 0);
        wirq(300);
        thi = 8'h00;
        efr[urt_pkg::PERIODIC_BIT] = 1'b0;
        pulse(0);
        repeat (10) begin
            pulse(2);
            pulse(3);
        end
        chk(irq, 0);
        wirq(40);
        repeat (5) pop();
        chk(lvl, 0);
        chk(rxd, 0);
        // clearing a flag with the fifo empty
        {thi, tlo} = 16'hffff;
        efr[urt_pkg::PERIODIC_BIT] = 1'b1;
        pulse(0);
        efr[urt_pkg::PERIODIC_BIT] = 1'b0;
        tick(50);
        chk(irq, 0);
        {thi, tlo} = 16'h0008;
        tick(40);
        chk(irq, 0);
        tlo = 8'h00;
        push(1);
        tick(40);
        chk(irq, 0);
        tlo = 8'h08;
        push(33);
        tick(2);
        chk(lvl, urt_pkg::FIFO_CAP);
        chk(rdy, 0);
        chk(ov, 1);
        chk(rxd, 1);
        efr[urt_pkg::PERIODIC_BIT] = 1'b1;
        fork
            push(2);
            repeat (36) pop();
        join
        chk(lvl, 0);
        pulse(0);
        chk(irq, 0);
        wirq(30);
        // next data sets dma up again
        rx_trig = 6'h01;
        push(1);
        tick(2);
        chk(rxd, 1);
        pop();
        chk(rxd, 0);
        end_sim();
    end
endmodule
